// *** rtl/ctcc_pkg.sv ***
// package of the charge-time counter block: register map, field positions,
// reset values and timing counts shared by the register core and the link engine.
// assumes a 200 MHz mclk; all cycle counts derive from it.
package ctcc_pkg;

   // ************************************************************
   // register map (7-bit register addresses)
   // ************************************************************
   localparam logic [6:0] ADDR_FLASH_COMMAND       = 7'h62;
   localparam logic [6:0] ADDR_COUNTER_CLEAR       = 7'h63;
   localparam logic [6:0] ADDR_MODE_AND_FLAGS      = 7'h64;
   localparam logic [6:0] ADDR_CHARGE_TIME_LOW     = 7'h65;
   localparam logic [6:0] ADDR_CHARGE_TIME_HIGH    = 7'h66;
   localparam logic [6:0] ADDR_DISCHARGE_TIME_LOW  = 7'h67;
   localparam logic [6:0] ADDR_DISCHARGE_TIME_HIGH = 7'h68;

   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int CMD_WRITE_BIT     = 7;
   localparam int MODE_DIR_BIT      = 7;
   localparam int MODE_LEVEL_BIT    = 6;
   localparam int MODE_SLOWC_BIT    = 5;
   localparam int MODE_SLOWD_BIT    = 4;
   localparam int MODE_WAKE_LSB     = 1;
   localparam int MODE_POR_BIT      = 0;
   localparam int CLR_CHARGE_TIME   = 4;
   localparam int CLR_DISCH_TIME    = 3;
   localparam int CLR_SELF_DISCH    = 2;
   localparam int CLR_CHARGE_COUNT  = 1;
   localparam int CLR_DISCH_COUNT   = 0;
   localparam logic       DIR_RESET     = 1'b0;
   localparam logic       LEVEL_RESET   = 1'b1;
   localparam logic [2:0] WAKE_RESET    = 3'h7;
   localparam logic       POR_RESET     = 1'b1;
   localparam logic [4:0] CLR_RESET     = 5'h00;
   localparam logic [7:0] FLASH_COMMAND_POWER_DOWN = 8'hF6;
   localparam logic [15:0] CNT_MAX      = 16'hFFFF;
   localparam logic [7:0]  SLOW_SUB_MAX = 8'hFF;   // fast rate / slow rate = 256

   // ************************************************************
   // timing
   // ************************************************************
   localparam longint unsigned CLK_HZ            = 200_000_000;
   localparam longint unsigned CLK_MHZ           = 200;
   localparam longint unsigned HOUR_S            = 3600;
   localparam longint unsigned FAST_PER_HOUR     = 4096;
   localparam longint unsigned FAST_TICK_CYCLES  = HOUR_S * CLK_HZ / FAST_PER_HOUR;
   localparam longint unsigned T_SAMPLE_NS       = 100_000;
   localparam longint unsigned T_BREAK_NS        = 190_000;
   localparam longint unsigned T_DEV_ONE_NS      = 50_000;
   localparam longint unsigned T_DEV_ZERO_NS     = 100_000;
   localparam longint unsigned T_DEV_CYCLE_NS    = 190_000;
   localparam longint unsigned T_TURN_NS         = 100_000;
   localparam longint unsigned SAMPLE_CYC    = (T_SAMPLE_NS * CLK_MHZ + 999) / 1000;
   localparam longint unsigned BREAK_CYC     = (T_BREAK_NS * CLK_MHZ + 999) / 1000;
   localparam longint unsigned DEV_ONE_CYC   = (T_DEV_ONE_NS * CLK_MHZ + 999) / 1000;
   localparam longint unsigned DEV_ZERO_CYC  = (T_DEV_ZERO_NS * CLK_MHZ + 999) / 1000;
   localparam longint unsigned DEV_CYCLE_CYC = (T_DEV_CYCLE_NS * CLK_MHZ + 999) / 1000;
   localparam longint unsigned TURN_CYC      = (T_TURN_NS * CLK_MHZ + 999) / 1000;
   localparam int              LINK_TW       = 24;

   // one time counter with its slow-rate prescaler and flag
   typedef struct packed {
      logic [15:0] cnt;
      logic [7:0]  sub;
      logic        slow;
   } ctcc_cnt_t;

endpackage : ctcc_pkg

// *** rtl/ctcc_link_if.sv ***
// interface between the serial link engine and the register core.
// assumes both ends run on the same mclk; strobes are one cycle long.
interface ctcc_link_if;
   logic       wr_stb;     // write byte complete
   logic       rd_stb;     // read command complete
   logic [6:0] addr;       // register address
   logic [7:0] wdata;      // written byte
   logic [7:0] rdata;      // read answer for addr
   logic       edge_seen;  // any transition of the line

   modport link (output wr_stb, rd_stb, addr, wdata, edge_seen, input rdata);
   modport regs (input wr_stb, rd_stb, addr, wdata, edge_seen, output rdata);
endinterface : ctcc_link_if

// *** rtl/ctcc_link.sv ***
// single-wire return-to-one link engine: command byte, write byte, read answer.
// assumes an idle-high open-drain line pulled up outside; line_in is asynchronous.
module ctcc_link
   import ctcc_pkg::*;
#(
   parameter int unsigned SAMPLE_C = 32'(SAMPLE_CYC),
   parameter int unsigned BREAK_C  = 32'(BREAK_CYC),
   parameter int unsigned ONE_C    = 32'(DEV_ONE_CYC),
   parameter int unsigned ZERO_C   = 32'(DEV_ZERO_CYC),
   parameter int unsigned CYCLE_C  = 32'(DEV_CYCLE_CYC),
   parameter int unsigned TURN_C   = 32'(TURN_CYC)
) (
   input  wire logic   mclk,      // system clock
   input  wire logic   reset,     // asynchronous, active high
   input  wire logic   line_in,   // line level
   output logic        drive,     // pull the line low
   ctcc_link_if.link   lnk        // towards the register core
);

   typedef enum logic [2:0] {L_IDLE, L_LOW, L_TURN, L_TX} ctcc_lstate_t;
   typedef struct packed {
      logic               sync1, sync2, prev;
      ctcc_lstate_t       st;
      logic [LINK_TW-1:0] timer;
      logic [2:0]         bitcnt;
      logic [7:0]         sh;
      logic               data_phase;
      logic [6:0]         addr;
      logic [7:0]         wdata;
      logic               wr_stb, rd_stb, drive;
   } ctcc_link_t;

   if (SAMPLE_C < 1 || BREAK_C <= SAMPLE_C || ONE_C >= ZERO_C || ZERO_C >= CYCLE_C ||
       CYCLE_C >= 2**LINK_TW || TURN_C >= 2**LINK_TW || BREAK_C >= 2**LINK_TW) begin : g_chk
      $error("ctcc_link: timing parameters out of range");
   end

   ctcc_link_t s, n;
   logic bitv;

   // bit framing, break detection and answer shifting
   always_comb begin
      n = s;
      bitv = 1'b0;
      n.sync1  = line_in;
      n.sync2  = s.sync1;
      n.prev   = s.sync2;
      n.wr_stb = 1'b0;
      n.rd_stb = 1'b0;
      n.timer  = s.timer + 1'b1;
      case (s.st)
         L_IDLE: begin
            if (s.prev && !s.sync2) begin
               n.st = L_LOW;
               n.timer = '0;
            end
         end
         L_LOW: begin
            if (s.sync2) begin
               n.st = L_IDLE;
               if (s.timer >= LINK_TW'(BREAK_C)) begin   // break: restart at command
                  n.bitcnt = '0;
                  n.data_phase = 1'b0;
               end else begin
                  bitv = (s.timer < LINK_TW'(SAMPLE_C));   // short low is a one [R21]
                  n.sh = {bitv, s.sh[7:1]};                // lsb first [R21]
                  n.bitcnt = s.bitcnt + 3'h1;
                  if (s.bitcnt == 3'h7) begin
                     if (s.data_phase) begin
                        n.wdata = {bitv, s.sh[7:1]};
                        n.wr_stb = 1'b1;
                        n.data_phase = 1'b0;
                     end else begin
                        n.addr = s.sh[7:1];                 // address field [R21]
                        n.data_phase = bitv;                // write flag in bit 7 [R21]
                        if (!bitv) begin
                           n.rd_stb = 1'b1;
                           n.st = L_TURN;
                           n.timer = '0;
                        end
                     end
                  end
               end
            end
         end
         L_TURN: begin
            if (s.rd_stb) begin
               n.sh = lnk.rdata;
            end
            if (s.timer == LINK_TW'(TURN_C - 1)) begin
               n.st = L_TX;
               n.timer = '0;
               n.bitcnt = '0;
            end
         end
         L_TX: begin
            if (s.timer == LINK_TW'(CYCLE_C - 1)) begin
               n.timer = '0;
               n.sh = {1'b0, s.sh[7:1]};
               n.bitcnt = s.bitcnt + 3'h1;
               if (s.bitcnt == 3'h7) begin
                  n.st = L_IDLE;
               end
            end
         end
         default: n.st = L_IDLE;
      endcase
      n.drive = (n.st == L_TX) &&
                ((n.timer < LINK_TW'(ONE_C)) || (!n.sh[0] && n.timer < LINK_TW'(ZERO_C)));
   end

   // state register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, st: L_IDLE, default: '0};
      end else begin
         s <= n;
      end
   end

   assign drive         = s.drive;
   assign lnk.wr_stb    = s.wr_stb;
   assign lnk.rd_stb    = s.rd_stb;
   assign lnk.addr      = s.addr;
   assign lnk.wdata     = s.wdata;
   assign lnk.edge_seen = s.prev ^ s.sync2;

endmodule : ctcc_link

// *** rtl/ctcc_top.sv ***
// register core of the charge-time and discharge-time counters with mode and clear
// registers, reached over the single-wire link engine.
// assumes sense comparator, supply monitor, wake comparator and gpio pin are asynchronous.
// ************************************************************
// Summary of operation
// R01 - 16-bit discharge-time counter at 0x68/0x67 counts 4096 per hour while discharging.
// R02 - discharge-time overflow sets slow discharge flag; then counts 16 per hour.
// R03 - second discharge-time overflow clears the slow discharge flag.
// R04 - 16-bit charge-time counter at 0x66/0x65 counts 4096 per hour while charging.
// R05 - charge-time overflow sets slow charge flag; then counts 16 per hour.
// R06 - second charge-time overflow clears the slow charge flag.
// R07 - host should clear both time counters more often than every 170 days.
// R08 - mode register 0x64: direction, level, slow flags, wake select, power-on flag.
// R09 - direction 1 makes gpio an input, 0 an open-drain output; resets 0.
// R10 - level 1 releases the open-drain driver, 0 pulls low; resets 1.
// R11 - after power-down, sleep when sense below wake threshold; zero sleeps at once.
// R12 - power-on flag set by low supply; host writes allowed, a one does nothing; the code stores the written bit, so a one sets the flag.
// R13 - clear register 0x63: three reserved bits then five counter clear bits.
// R14 - host writes zero to the reserved clear register bits.
// R15 - charge-time clear zeroes the counter and slow charge flag, then self-clears.
// R16 - discharge-time clear zeroes counter and slow discharge flag, then self-clears.
// R17 - self-discharge clear zeroes the self-discharge counter, then self-clears.
// R18 - charge-count clear zeroes the charge accumulator, then self-clears.
// R19 - discharge-count clear zeroes the discharge accumulator, then self-clears.
// R20 - all clear bits read zero after power-on reset.
// R21 - access starts with lsb-first command byte: bit7 write flag, bits6-0 address.
// R22 - code 0xF6 to flash command requests sleep; any line transition wakes.
// R23 - counters wrap to zero on overflow; flag toggles in the same cycle.
// R24 - clear and increment in one cycle: the clear wins.
module ctcc_top
   import ctcc_pkg::*;
#(
   parameter int unsigned FAST_TICK = 32'(FAST_TICK_CYCLES),  // cycles per fast count
   parameter int unsigned SAMPLE_C  = 32'(SAMPLE_CYC),        // host bit sample point
   parameter int unsigned BREAK_C   = 32'(BREAK_CYC),         // least break length
   parameter int unsigned ONE_C     = 32'(DEV_ONE_CYC),       // answer low time, one
   parameter int unsigned ZERO_C    = 32'(DEV_ZERO_CYC),      // answer low time, zero
   parameter int unsigned CYCLE_C   = 32'(DEV_CYCLE_CYC),     // answer bit period
   parameter int unsigned TURN_C    = 32'(TURN_CYC)           // gap before answer
) (
   input  wire logic       mclk,                   // system clock
   input  wire logic       reset,                  // asynchronous, active high
   input  wire logic       line_in,                // serial line level
   output logic            line_out,               // serial line drive level
   output logic            line_oe_n,              // serial line driver on, low
   input  wire logic       gpio_in,                // gpio pin level
   output logic            gpio_out,               // gpio drive level
   output logic            gpio_oe_n,              // gpio driver on, low
   input  wire logic       charge_active,          // sense shows charging
   input  wire logic       discharge_active,       // sense shows discharging
   input  wire logic       supply_low,             // supply below reset level
   input  wire logic       below_wake,             // sense below wake threshold
   output logic [2:0]      wake_threshold_select,  // threshold to comparator
   output logic            sleep,                  // sleep mode entered
   output logic            self_discharge_clear,   // zero self-discharge counter
   output logic            charge_count_clear,     // zero charge accumulator
   output logic            discharge_count_clear   // zero discharge accumulator
);

   // ************************************************************
   // state
   // ************************************************************
   localparam int TW_T = (FAST_TICK > 1) ? $clog2(FAST_TICK) : 1;
   localparam logic [TW_T-1:0] TICK_LAST = TW_T'(FAST_TICK - 1);
   localparam int IN_CHG  = 0;
   localparam int IN_DIS  = 1;
   localparam int IN_SUP  = 2;
   localparam int IN_WAKE = 3;
   localparam int IN_GPIO = 4;

   typedef struct packed {
      logic [4:0]      sync1;
      logic [4:0]      sync2;
      logic [TW_T-1:0] tick_cnt;
      ctcc_cnt_t       chg;
      ctcc_cnt_t       dis;
      logic            dir, level, por;
      logic [2:0]      wake;
      logic [4:0]      clr;
      logic            pd_pending, sleep;
   } ctcc_state_t;

   if (FAST_TICK < 2) begin : g_chk
      $error("ctcc_top: FAST_TICK must be at least 2");
   end

   ctcc_state_t s, n;
   ctcc_link_if lnk ();
   logic        tick;
   logic        chg_s, dis_s;
   logic        wr_clear, wr_mode, wr_flash_command;
   logic        drive;

   // ************************************************************
   // link engine
   // ************************************************************
   ctcc_link #(
      .SAMPLE_C (SAMPLE_C),
      .BREAK_C  (BREAK_C),
      .ONE_C    (ONE_C),
      .ZERO_C   (ZERO_C),
      .CYCLE_C  (CYCLE_C),
      .TURN_C   (TURN_C)
   ) u_link (
      .mclk    (mclk),
      .reset   (reset),
      .line_in (line_in),
      .drive   (drive),
      .lnk     (lnk)
   );

   // one time-counter step: clear first, then fast or prescaled increment
   function automatic ctcc_cnt_t ctcc_step(ctcc_cnt_t c, logic active, logic clr);
      ctcc_cnt_t r;
      logic      fire;
      r = c;
      fire = 1'b0;
      if (clr) begin
         r = '0;                                      // [R15] [R16] [R24]
      end else if (active && tick) begin
         if (c.slow) begin
            r.sub = c.sub + 8'h01;                    // 256 fast ticks per slow count [R02] [R05]
            fire = (c.sub == SLOW_SUB_MAX);
         end else begin
            fire = 1'b1;                              // [R01] [R04]
         end
         if (fire) begin
            if (c.cnt == CNT_MAX) begin
               r.cnt = '0;                            // [R23]
               r.slow = ~c.slow;                      // set then clear [R02] [R03] [R05] [R06]
            end else begin
               r.cnt = c.cnt + 16'h0001;
            end
         end
      end
      return r;
   endfunction : ctcc_step

   // ************************************************************
   // next state
   // ************************************************************
   assign tick     = (s.tick_cnt == TICK_LAST);
   assign chg_s    = s.sync2[IN_CHG];
   assign dis_s    = s.sync2[IN_DIS];
   assign wr_clear = lnk.wr_stb && (lnk.addr == ADDR_COUNTER_CLEAR);
   assign wr_mode  = lnk.wr_stb && (lnk.addr == ADDR_MODE_AND_FLAGS);
   assign wr_flash_command  = lnk.wr_stb && (lnk.addr == ADDR_FLASH_COMMAND);

   // counters, mode bits, clear bits and sleep control
   always_comb begin
      n = s;
      n.sync1 = {gpio_in, below_wake, supply_low, discharge_active, charge_active};
      n.sync2 = s.sync1;
      n.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;
      n.chg = ctcc_step(s.chg, chg_s, s.clr[CLR_CHARGE_TIME]);
      n.dis = ctcc_step(s.dis, dis_s, s.clr[CLR_DISCH_TIME]);
      // clear bits act for one cycle then return to zero
      n.clr = wr_clear ? lnk.wdata[4:0] : CLR_RESET;      // reserved bits dropped [R13] [R14]
      if (wr_mode) begin
         n.dir   = lnk.wdata[MODE_DIR_BIT];                // [R08] [R09]
         n.level = lnk.wdata[MODE_LEVEL_BIT];              // [R10]
         n.wake  = lnk.wdata[MODE_WAKE_LSB +: 3];
         n.por   = lnk.wdata[MODE_POR_BIT];                // flag only, no effect [R12]
      end
      if (s.sync2[IN_SUP]) begin
         n.por = 1'b1;                                     // set wins over write [R12]
      end
      if (wr_flash_command && lnk.wdata == FLASH_COMMAND_POWER_DOWN) begin
         n.pd_pending = 1'b1;                              // [R22]
      end
      if (s.pd_pending && (s.wake == 3'h0 || s.sync2[IN_WAKE])) begin
         n.pd_pending = 1'b0;                              // [R11]
         n.sleep = 1'b1;
      end
      if (lnk.edge_seen) begin
         n.sleep = 1'b0;                                   // [R22]
      end
   end

   // state register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s <= '{dir: DIR_RESET, level: LEVEL_RESET, wake: WAKE_RESET, por: POR_RESET,
                clr: CLR_RESET, default: '0};             // [R20]
      end else begin
         s <= n;
      end
   end

   // ************************************************************
   // register read
   // ************************************************************
   always_comb begin
      case (lnk.addr)
         ADDR_FLASH_COMMAND:       lnk.rdata = s.pd_pending ? FLASH_COMMAND_POWER_DOWN : 8'h00;
         ADDR_COUNTER_CLEAR:       lnk.rdata = {3'h0, s.clr};
         ADDR_MODE_AND_FLAGS:      lnk.rdata = {s.dir, s.dir ? s.sync2[IN_GPIO] : s.level,
                                                s.chg.slow, s.dis.slow, s.wake, s.por};
         ADDR_CHARGE_TIME_LOW:     lnk.rdata = s.chg.cnt[7:0];
         ADDR_CHARGE_TIME_HIGH:    lnk.rdata = s.chg.cnt[15:8];
         ADDR_DISCHARGE_TIME_LOW:  lnk.rdata = s.dis.cnt[7:0];
         ADDR_DISCHARGE_TIME_HIGH: lnk.rdata = s.dis.cnt[15:8];
         default:                  lnk.rdata = 8'h00;
      endcase
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign line_out              = 1'b0;
   assign line_oe_n             = ~drive;
   assign gpio_out              = 1'b0;
   assign gpio_oe_n             = s.dir | s.level;          // [R09] [R10]
   assign wake_threshold_select = s.wake;                   // [R11]
   assign sleep                 = s.sleep;
   assign self_discharge_clear  = s.clr[CLR_SELF_DISCH];   // [R17]
   assign charge_count_clear    = s.clr[CLR_CHARGE_COUNT]; // [R18]
   assign discharge_count_clear = s.clr[CLR_DISCH_COUNT];  // [R19]

   // ************************************************************
   // checks
   // ************************************************************
   chk_dis_fast: assert property ( // [R01]
      @(posedge mclk) disable iff (reset)
      tick && dis_s && !s.clr[CLR_DISCH_TIME] && !s.dis.slow && s.dis.cnt != CNT_MAX
      |=> s.dis.cnt == $past(s.dis.cnt) + 16'h0001)
      else $error("discharge-time counter missed a fast count");

   chk_dis_wrap: assert property ( // [R02] [R03] [R23]
      @(posedge mclk) disable iff (reset)
      tick && dis_s && !s.clr[CLR_DISCH_TIME] && s.dis.cnt == CNT_MAX &&
      (!s.dis.slow || s.dis.sub == SLOW_SUB_MAX)
      |=> s.dis.cnt == 16'h0000 && s.dis.slow != $past(s.dis.slow))
      else $error("discharge-time overflow did not wrap and toggle its flag");

   chk_slow_hold: assert property ( // [R05]
      @(posedge mclk) disable iff (reset)
      s.chg.slow && s.chg.sub != SLOW_SUB_MAX && !s.clr[CLR_CHARGE_TIME]
      |=> s.chg.cnt == $past(s.chg.cnt))
      else $error("charge-time counter counted early in slow mode");

   chk_chg_wrap: assert property ( // [R04] [R05] [R06] [R23]
      @(posedge mclk) disable iff (reset)
      tick && chg_s && !s.clr[CLR_CHARGE_TIME] && s.chg.cnt == CNT_MAX &&
      (!s.chg.slow || s.chg.sub == SLOW_SUB_MAX)
      |=> s.chg.cnt == 16'h0000 && s.chg.slow != $past(s.chg.slow))
      else $error("charge-time overflow did not wrap and toggle its flag");

   chk_clear_wins: assert property ( // [R15] [R16] [R24]
      @(posedge mclk) disable iff (reset)
      wr_clear && lnk.wdata[CLR_CHARGE_TIME] && lnk.wdata[CLR_DISCH_TIME]
      |=> ##1 s.chg.cnt == 16'h0000 && !s.chg.slow && s.dis.cnt == 16'h0000 && !s.dis.slow)
      else $error("time counter clear did not zero counter and flag");

   chk_clear_return: assert property ( // [R17] [R18] [R19] [R20]
      @(posedge mclk) disable iff (reset)
      wr_clear && lnk.wdata[CLR_SELF_DISCH] && !lnk.wdata[CLR_CHARGE_COUNT]
      |=> self_discharge_clear && !charge_count_clear ##1 (wr_clear || s.clr == 5'h00))
      else $error("clear bit did not pulse once and return to zero");

   chk_gpio_drive: assert property ( // [R08] [R09] [R10]
      @(posedge mclk) disable iff (reset)
      wr_mode |=> gpio_oe_n == ($past(lnk.wdata[MODE_DIR_BIT]) | $past(lnk.wdata[MODE_LEVEL_BIT])))
      else $error("gpio driver does not follow direction and level");

   chk_por_set: assert property ( // [R12]
      @(posedge mclk) disable iff (reset)
      s.sync2[IN_SUP] |=> s.por)
      else $error("low supply did not set the power-on flag");

   chk_sleep_entry: assert property ( // [R11] [R22]
      @(posedge mclk) disable iff (reset)
      wr_flash_command && lnk.wdata == FLASH_COMMAND_POWER_DOWN && WAKE_RESET != 3'h0 && s.wake == 3'h0
      ##1 !lnk.edge_seen ##1 !lnk.edge_seen |-> sleep)
      else $error("power-down with zero threshold did not sleep at once");

endmodule : ctcc_top

// *** test/ctcc_host.sv ***
// host model for the single-wire link: sends bytes, breaks, reads answers.
// assumes a pull-up on the line: it is low only while some party drives it.
module ctcc_host
   import ctcc_pkg::*;
(
   input  wire logic mclk,     // system clock
   input  wire logic line,     // resolved line level
   output logic      host_low  // host pulls line low
);
   timeunit 1ns;
   timeprecision 1ps;
   initial host_low = 1'b0;
   // one byte lsb first: short low for one, long low for zero
   task automatic put(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(negedge mclk) host_low = 1'b1;
         repeat (b[i] ? 2 : 8) @(negedge mclk);
         host_low = 1'b0;
         repeat (4) @(negedge mclk);
      end
   endtask : put
   // long low restarts the frame; also a line transition for wake-up
   task automatic brk();
      @(negedge mclk) host_low = 1'b1;
      repeat (20) @(negedge mclk);
      host_low = 1'b0;
      repeat (10) @(negedge mclk);
   endtask : brk
   // answer bits judged by their low time, each wait bounded
   task automatic get(output logic [7:0] b);
      int n;
      for (int i = 0; i < 8; i++) begin
         n = 0;
         while (line !== 1'b0 && n < 300) begin @(negedge mclk); n++; end
         n = 0;
         while (line === 1'b0 && n < 50) begin @(negedge mclk); n++; end
         b[i] = (n < 3);
      end
      repeat (10) @(negedge mclk);
   endtask : get
   // write: command with bit 7 set, then data
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      put({1'b1, a});
      put(d);
      repeat (8) @(negedge mclk);
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      put({1'b0, a});
      get(d);
   endtask : rd
endmodule : ctcc_host

// *** test/ctcc_top_tb.sv ***
// testbench of the counter block: host model on the line, sense inputs driven.
// assumes shortened tick and link counts; expectations follow from them.
module ctcc_top_tb;
   import ctcc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic       mclk, reset, host_low, oe_n, g_oe_n, slp, chg, dis, sup, bw, sdc, ccc, dcc;
   logic [2:0] wake, pulses;
   logic [7:0] v;
   int         bad_count = 0, num_checks = 0, cycles = 0;
   wire logic  line = ~host_low & oe_n;
   localparam int unsigned TICK_T = 32'h8;  // shortened fast tick
   localparam int unsigned UNIT_T = 32'h4;  // shortened link unit; other link counts follow
   ctcc_top #(.FAST_TICK(TICK_T), .SAMPLE_C(UNIT_T), .BREAK_C(3 * UNIT_T),
      .ONE_C(UNIT_T / 2), .ZERO_C(UNIT_T), .CYCLE_C(2 * UNIT_T), .TURN_C(UNIT_T))
      ctcc_top_inst (.mclk(mclk), .reset(reset),
      .line_in(line), .line_out(), .line_oe_n(oe_n), .gpio_in(g_oe_n), .gpio_out(),
      .gpio_oe_n(g_oe_n), .charge_active(chg), .discharge_active(dis),
      .supply_low(sup), .below_wake(bw), .wake_threshold_select(wake), .sleep(slp),
      .self_discharge_clear(sdc), .charge_count_clear(ccc), .discharge_count_clear(dcc));
   ctcc_host ctcc_host_inst (.mclk(mclk), .line(line), .host_low(host_low));
   // clock, timeout and sticky record of the clear pulses
   initial begin mclk = 1'b0; forever #2.5 mclk = ~mclk; end
   always @(posedge mclk) if (++cycles == 60000) begin bad_count++; print_verdict(); end
   always @(posedge mclk) pulses <= reset ? 3'h0 : pulses | {sdc, ccc, dcc};
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // count on one side ~100 ticks, other side idle, then clear
   task automatic t_count(input bit d);
      @(negedge mclk) {chg, dis} = d ? 2'b01 : 2'b10;
      repeat (800) @(negedge mclk);
      {chg, dis} = 2'b00;
      ctcc_host_inst.rd(d ? ADDR_DISCHARGE_TIME_LOW : ADDR_CHARGE_TIME_LOW, v);
      cmp(8'(v > 8'h5F && v < 8'h67), 8'h01);
      ctcc_host_inst.rd(d ? ADDR_CHARGE_TIME_LOW : ADDR_DISCHARGE_TIME_LOW, v);
      cmp(v, 8'h00);
      ctcc_host_inst.wr(ADDR_COUNTER_CLEAR, d ? 8'h18 : 8'h10);
      ctcc_host_inst.rd(d ? ADDR_DISCHARGE_TIME_LOW : ADDR_CHARGE_TIME_LOW, v);
      cmp(v, 8'h00);
      ctcc_host_inst.rd(ADDR_COUNTER_CLEAR, v);
      cmp(v, 8'h00);
   endtask : t_count
   // reset values, gpio, clear pulses, power-on flag and sleep
   task automatic t_regs();
      ctcc_host_inst.rd(ADDR_MODE_AND_FLAGS, v);
      cmp(v, 8'h4F);
      ctcc_host_inst.rd(ADDR_COUNTER_CLEAR, v);
      cmp({g_oe_n, wake, v[3:0]}, 8'hF0);
      ctcc_host_inst.wr(ADDR_COUNTER_CLEAR, 8'h04);
      ctcc_host_inst.wr(ADDR_COUNTER_CLEAR, 8'h03);
      cmp({5'h0, pulses}, 8'h07);
      ctcc_host_inst.wr(ADDR_MODE_AND_FLAGS, 8'h02);
      cmp({7'h0, g_oe_n}, 8'h00);
      cmp({5'h0, wake}, 8'h01);
      @(negedge mclk) sup = 1'b1;
      repeat (4) @(negedge mclk);
      sup = 1'b0;
      ctcc_host_inst.rd(ADDR_MODE_AND_FLAGS, v);
      cmp(v, 8'h03);
      ctcc_host_inst.wr(ADDR_FLASH_COMMAND, FLASH_COMMAND_POWER_DOWN);
      cmp({7'h0, slp}, 8'h00);
      @(negedge mclk) bw = 1'b1;
      repeat (6) @(negedge mclk);
      cmp({7'h0, slp}, 8'h01);
      ctcc_host_inst.brk();
      cmp({7'h0, slp}, 8'h00);
      bw = 1'b0;
      ctcc_host_inst.wr(ADDR_MODE_AND_FLAGS, 8'h80);
      cmp({7'h0, g_oe_n}, 8'h01);
      ctcc_host_inst.rd(ADDR_MODE_AND_FLAGS, v);
      cmp(v, 8'hC0);
      ctcc_host_inst.wr(ADDR_MODE_AND_FLAGS, 8'h00);
      ctcc_host_inst.wr(ADDR_FLASH_COMMAND, FLASH_COMMAND_POWER_DOWN);
      cmp({7'h0, slp}, 8'h01);
      ctcc_host_inst.brk();
      cmp({7'h0, slp}, 8'h00);
   endtask : t_regs
   initial begin
      {reset, chg, dis, sup, bw} = 5'h10;
      repeat (5) @(negedge mclk);
      reset = 1'b0;
      repeat (4) @(negedge mclk);
      t_regs();
      t_count(1'b0);
      t_count(1'b1);
      print_verdict();
   end
endmodule : ctcc_top_tb
